// ---- logic/pgc_pin_ctrl.sv ----
/*
 * Pin function control: configuration register, channel sequencer that
 * drives the external mux code, sync handling and fault pin modes.
 * Assumes an AHB-Lite master, and pins that arrive asynchronously.
 */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module pgc_pin_ctrl (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        SYNC_N_IN,
    input  wire logic        FAULT_PIN_IN,
    output logic             FAULT_PIN_OUT,
    output logic             FAULT_PIN_OE_OUT,
    input  wire logic        CONV_FAULT_IN,
    output logic             BRIDGE_SWITCH_OUT,
    output logic             IO_PIN_ZERO_OUT,
    output logic             IO_PIN_ONE_OUT,
    output logic             OUT_PIN_TWO_OUT,
    output logic             OUT_PIN_THREE_OUT,
    output logic             IO_PINS_LO_OE_OUT,
    output logic             OUT_PINS_HI_OE_OUT,
    output logic             MOD_RESET_OUT,
    output logic             CONV_START_OUT,
    output logic      [3:0]  CHANNEL_OUT,
    output logic             IRQ_OUT
);
    import pgc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic       rst_meta;
    logic       rst_n;
    logic [1:0] sync_meta;
    logic [1:0] sync_s;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Index 0 is sync, index 1 is the fault pin
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= 2'h3;
            sync_s    <= 2'h3;
        end else begin
            sync_meta <= {FAULT_PIN_IN, SYNC_N_IN};
            sync_s    <= sync_meta;
        end
    end

    logic fault_in_s;
    logic conv_fault_s;
    logic sync_low;
    assign sync_low   = ~sync_s[0];
    assign fault_in_s = sync_s[1];

    // Converter fault comes from the same clock domain
    assign conv_fault_s = CONV_FAULT_IN;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0]           pin_cfg;
    logic [16:0]           seq_ctrl;
    logic [15:0]           settle;
    logic [IRQ_BITS-1:0]   irq_status;
    logic [IRQ_BITS-1:0]   irq_mask;
    logic [IRQ_BITS-1:0]   irq_event;

    logic                  ph_write;
    logic [7:0]            ph_addr;
    logic                  addr_ok;

    always_comb begin
        if (HADDR_IN[7:0] == ADDR_PIN_CFG || HADDR_IN[7:0] == ADDR_SEQ_CTRL
                || HADDR_IN[7:0] == ADDR_SETTLE || HADDR_IN[7:0] == ADDR_STATUS
                || HADDR_IN[7:0] == ADDR_IRQ_STATUS || HADDR_IN[7:0] == ADDR_IRQ_MASK) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Address phase capture; the slave never stalls
    // Only writes need the captured phase: read data is
    // registered at the address edge itself, so a read
    // right after a write to the same word sees the old value
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else begin
            ph_write <= HSEL_IN & HREADY_IN & HTRANS_IN[1] & HWRITE_IN & addr_ok;
            ph_addr  <= HADDR_IN[7:0];
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end
    end

    logic fault_lvl_view;
    logic [15:0] pin_cfg_view;

    // Fault level bit reads the sampled pin while in input mode
    always_comb begin
        if (pin_cfg[BIT_FAULT_MODE +: 2] == FAULT_INPUT) begin
            fault_lvl_view = fault_in_s;
        end else begin
            fault_lvl_view = pin_cfg[BIT_FAULT_LVL];
        end
        pin_cfg_view = {1'b0, pin_cfg[14:9], fault_lvl_view, 8'h00};
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            pin_cfg <= PIN_CFG_RESET;
        end else if (ph_write && ph_addr == ADDR_PIN_CFG) begin
            pin_cfg <= HWDATA_IN[15:0] & PIN_CFG_WMASK;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            seq_ctrl <= 17'h00000;
            settle   <= SETTLE_RESET;
            irq_mask <= '0;
        end else if (ph_write) begin
            if (ph_addr == ADDR_SEQ_CTRL) begin
                seq_ctrl <= {HWDATA_IN[31:16] != 16'h0000 ? 1'b0 : 1'b0,
                             HWDATA_IN[15:0]};
            end else if (ph_addr == ADDR_SETTLE) begin
                settle <= HWDATA_IN[15:0];
            end else if (ph_addr == ADDR_IRQ_MASK) begin
                irq_mask <= HWDATA_IN[IRQ_BITS-1:0];
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else begin
            if (ph_write && ph_addr == ADDR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~HWDATA_IN[IRQ_BITS-1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel sequencer

    pgc_seq_t    state;
    pgc_seq_t    next_state;
    logic [3:0]  channel;
    logic [3:0]  next_channel;
    logic [15:0] count;
    logic        multi_ch;
    logic        alt_mode;
    logic        hard_sync;
    logic        pass_done;
    logic        conv_done;
    logic [15:0] ch_en;

    assign ch_en     = seq_ctrl[15:0];
    assign multi_ch  = (ch_en & (ch_en - 16'h0001)) != 16'h0000;
    assign alt_mode  = seq_ctrl[BIT_SYNC_ALTERNATE_SELECT] & multi_ch;
    // Plain sync mode resets the sequencer state and holds the modulator; alternate mode only stalls
    assign hard_sync = pin_cfg[BIT_SYNC_EN] & ~alt_mode & sync_low;

    // Next enabled channel, wrapping after channel 15
    always_comb begin
        next_channel = channel;
        for (int i = MAX_CHANNELS; i >= 1; i--) begin
            if (ch_en[4'(channel + 4'(i))]) begin
                next_channel = 4'(channel + 4'(i));
            end
        end
    end

    assign conv_done = (state == SEQ_CONV) && (count == 16'(CONV_CYCLES - 1));
    assign pass_done = conv_done && (next_channel <= channel);

    always_comb begin
        next_state = state;
        case (state)
            SEQ_IDLE: begin
                if (ch_en != 16'h0000) begin
                    next_state = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                if (count >= settle) begin
                    next_state = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                // Stall at channel switch while sync is low
                if (!(alt_mode && pin_cfg[BIT_SYNC_EN] && sync_low)) begin
                    next_state = SEQ_CONV;
                end
            end
            SEQ_CONV: begin
                if (conv_done) begin
                    next_state = SEQ_SETTLE;
                end
            end
            default: next_state = SEQ_IDLE;
        endcase
        if (hard_sync || ch_en == 16'h0000) begin
            next_state = SEQ_IDLE;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state   <= SEQ_IDLE;
            count   <= 16'h0000;
            channel <= 4'h0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                count <= 16'h0000;
            end else begin
                count <= count + 16'h0001;
            end
            if (state == SEQ_IDLE && next_state == SEQ_SETTLE && !ch_en[channel]) begin
                channel <= next_channel;
            end else if (conv_done) begin
                channel <= next_channel;
            end
        end
    end

    assign irq_event = {conv_done, CONV_FAULT_IN | (fault_in_s == 1'b0 &&
                        pin_cfg[BIT_FAULT_MODE +: 2] == FAULT_INPUT), pass_done};

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    logic any_error;
    // Input mode folds the inverted pin into the error flag
    assign any_error = conv_fault_s
        | ((pin_cfg[BIT_FAULT_MODE +: 2] == FAULT_INPUT) & ~fault_in_s);

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_PIN_OUT    <= 1'b1;
            FAULT_PIN_OE_OUT <= 1'b0;
        end else begin
            case (pin_cfg[BIT_FAULT_MODE +: 2])
                FAULT_OPEN: begin
                    // Drive low only on error, so devices can share a pull-up
                    FAULT_PIN_OUT    <= 1'b0;
                    FAULT_PIN_OE_OUT <= any_error;
                end
                FAULT_PUSH: begin
                    FAULT_PIN_OUT    <= pin_cfg[BIT_FAULT_LVL];
                    FAULT_PIN_OE_OUT <= 1'b1;
                end
                default: begin
                    FAULT_PIN_OUT    <= 1'b1;
                    FAULT_PIN_OE_OUT <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            BRIDGE_SWITCH_OUT  <= 1'b0;
            IO_PIN_ZERO_OUT    <= 1'b0;
            IO_PIN_ONE_OUT     <= 1'b0;
            OUT_PIN_TWO_OUT    <= 1'b0;
            OUT_PIN_THREE_OUT  <= 1'b0;
            IO_PINS_LO_OE_OUT  <= 1'b0;
            OUT_PINS_HI_OE_OUT <= 1'b0;
        end else begin
            BRIDGE_SWITCH_OUT  <= pin_cfg[BIT_BRIDGE_SW];
            IO_PIN_ZERO_OUT    <= pin_cfg[BIT_MUX_EN] & channel[0];
            IO_PIN_ONE_OUT     <= pin_cfg[BIT_MUX_EN] & channel[1];
            OUT_PIN_TWO_OUT    <= pin_cfg[BIT_MUX_EN] & channel[2];
            OUT_PIN_THREE_OUT  <= pin_cfg[BIT_MUX_EN] & channel[3];
            IO_PINS_LO_OE_OUT  <= pin_cfg[BIT_MUX_EN];
            OUT_PINS_HI_OE_OUT <= pin_cfg[BIT_OUT_HI_EN];
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            MOD_RESET_OUT  <= 1'b1;
            CONV_START_OUT <= 1'b0;
            CHANNEL_OUT    <= 4'h0;
        end else begin
            MOD_RESET_OUT  <= hard_sync;
            CONV_START_OUT <= (state == SEQ_WAIT) && (next_state == SEQ_CONV);
            CHANNEL_OUT    <= channel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            HRDATA_OUT <= 32'h00000000;
        end else if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) begin
            if (HADDR_IN[7:0] == ADDR_PIN_CFG) begin
                HRDATA_OUT <= {16'h0000, pin_cfg_view};
            end else if (HADDR_IN[7:0] == ADDR_SEQ_CTRL) begin
                HRDATA_OUT <= {16'h0000, seq_ctrl[15:0]};
            end else if (HADDR_IN[7:0] == ADDR_SETTLE) begin
                HRDATA_OUT <= {16'h0000, settle};
            end else if (HADDR_IN[7:0] == ADDR_STATUS) begin
                HRDATA_OUT <= {24'h000000, any_error, sync_low, state, channel};
            end else if (HADDR_IN[7:0] == ADDR_IRQ_STATUS) begin
                HRDATA_OUT <= {29'h00000000, irq_status};
            end else if (HADDR_IN[7:0] == ADDR_IRQ_MASK) begin
                HRDATA_OUT <= {29'h00000000, irq_mask};
            end else begin
                HRDATA_OUT <= 32'h00000000;
            end
        end
    end

endmodule

`default_nettype wire

// ---- logic/pgc_pkg.sv ----
/*
 * Constants for the pin function control block: register map, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and an AHB-Lite bus with 32-bit data.
 */
// Notes on behaviour
// - Bridge switch sinks current only while its enable bit is set.
// - Output pins two and three are driven only while their enable bit is set.
// - Mux drive enable puts the sequencer channel code on the four pins.
// - Sequencer covers at most 16 channels; host moves input pair after each pass.
// - Optional programmable settling delay after every mux select code change.
// - Sync enable (reset one): low sync holds modulator and filter in reset.
// - Alternate sync: low sync at channel switch stalls the next conversion.
// - Alternate sync applies only with more than one channel enabled.
// - Fault mode 00 disables pin; 01 input, inverted level ORed into error flag.
// - Fault mode 10: ORed error flags, inverted, driven open-drain.
// - Fault mode 11: plain push-pull output following the fault level bit.
// - Fault level bit drives output mode; reads sampled pin in input mode.
`default_nettype none

package pgc_pkg;

    // Configuration word index; its byte address is four times the index
    localparam logic [7:0] IDX_PIN_CFG     = 8'h06;
    localparam logic [7:0] ADDR_PIN_CFG    = {IDX_PIN_CFG[5:0], 2'b00};
    // Block's own registers sit above the configuration word
    localparam logic [7:0] ADDR_SEQ_CTRL   = 8'h20;
    localparam logic [7:0] ADDR_SETTLE     = 8'h24;
    localparam logic [7:0] ADDR_STATUS     = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h30;

    // Configuration word fields
    localparam int BIT_RESERVED   = 15;
    localparam int BIT_BRIDGE_SW  = 14;
    localparam int BIT_OUT_HI_EN  = 13;
    localparam int BIT_MUX_EN     = 12;
    localparam int BIT_SYNC_EN    = 11;
    localparam int BIT_FAULT_MODE = 9;
    localparam int BIT_FAULT_LVL  = 8;

    localparam logic [15:0] PIN_CFG_RESET  = 16'h0800;
    localparam logic [15:0] PIN_CFG_WMASK  = 16'h7F00;

    // Sequencer control fields
    localparam int BIT_SEQ_RUN    = 0;
    localparam int BIT_SYNC_ALTERNATE_SELECT   = 1;
    localparam int BIT_CH_ENABLE  = 16;
    localparam int MAX_CHANNELS   = 16;

    localparam logic [1:0] FAULT_OFF   = 2'h0;
    localparam logic [1:0] FAULT_INPUT = 2'h1;
    localparam logic [1:0] FAULT_OPEN  = 2'h2;
    localparam logic [1:0] FAULT_PUSH  = 2'h3;

    // Conversion time per channel
    localparam int CLK_MHZ         = 50;
    localparam int CONV_TIME_US    = 20;
    localparam int CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;
    localparam logic [15:0] SETTLE_RESET = 16'h0000;

    // Interrupt status bits
    localparam int IRQ_PASS_DONE   = 0;
    localparam int IRQ_FAULT       = 1;
    localparam int IRQ_CONV_DONE   = 2;
    localparam int IRQ_BITS        = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_SETTLE = 2'b01,
        SEQ_CONV   = 2'b10,
        SEQ_WAIT   = 2'b11
    } pgc_seq_t;

endpackage

`default_nettype wire

// ---- sim/pgc_pin_monitor.sv ----
/*
 * Port-level checker for pgc_pin_ctrl, bound to every instance.
 * Assumes the single clock and active-low reset of the top module.
 */
`timescale 1ns/1ns
`default_nettype none

module pgc_pin_monitor (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [31:0] HRDATA_OUT,
    input  wire logic        HREADYOUT_OUT,
    input  wire logic        HRESP_OUT,
    input  wire logic        FAULT_PIN_OE_OUT,
    input  wire logic        BRIDGE_SWITCH_OUT,
    input  wire logic        IO_PIN_ZERO_OUT,
    input  wire logic        IO_PIN_ONE_OUT,
    input  wire logic        OUT_PIN_TWO_OUT,
    input  wire logic        OUT_PIN_THREE_OUT,
    input  wire logic        IO_PINS_LO_OE_OUT,
    input  wire logic        OUT_PINS_HI_OE_OUT,
    input  wire logic        MOD_RESET_OUT,
    input  wire logic        CONV_START_OUT,
    input  wire logic [3:0]  CHANNEL_OUT
);
    logic [3:0] mux_code;
    assign mux_code = {OUT_PIN_THREE_OUT, OUT_PIN_TWO_OUT, IO_PIN_ONE_OUT, IO_PIN_ZERO_OUT};

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // A conversion lasts far longer than eight cycles
    sequence quiet_after_start;
        !CONV_START_OUT [*8];
    endsequence

    a_ready_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus slave stalled or answered with an error");
    a_read_hold: assert property (!(HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) |=> $stable(HRDATA_OUT))
        else $error("read data changed without a read");
    a_mux_code: assert property (IO_PINS_LO_OE_OUT |-> mux_code == CHANNEL_OUT)
        else $error("mux select code differs from channel");
    a_mux_idle: assert property (!IO_PINS_LO_OE_OUT |-> mux_code == 4'h0)
        else $error("mux select code active while disabled");
    a_start_single: assert property (CONV_START_OUT |=> quiet_after_start)
        else $error("conversion start repeated too soon");
    a_start_settled: assert property (CONV_START_OUT |-> $stable(CHANNEL_OUT))
        else $error("conversion started while channel changed");
    a_no_start_held: assert property (MOD_RESET_OUT |-> !CONV_START_OUT)
        else $error("conversion started while modulator held");
    a_reset_pins_off: assert property ($rose(RESET_N_IN) |->
        !BRIDGE_SWITCH_OUT && !FAULT_PIN_OE_OUT && !OUT_PINS_HI_OE_OUT && !IO_PINS_LO_OE_OUT)
        else $error("pin function active after reset");
    a_mod_held: assert property ($rose(RESET_N_IN) |-> MOD_RESET_OUT)
        else $error("modulator not held at reset release");
endmodule

bind pgc_pin_ctrl pgc_pin_monitor u_mon (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .HSEL_IN(HSEL_IN),
    .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .FAULT_PIN_OE_OUT(FAULT_PIN_OE_OUT),
    .BRIDGE_SWITCH_OUT(BRIDGE_SWITCH_OUT), .IO_PIN_ZERO_OUT(IO_PIN_ZERO_OUT),
    .IO_PIN_ONE_OUT(IO_PIN_ONE_OUT), .OUT_PIN_TWO_OUT(OUT_PIN_TWO_OUT),
    .OUT_PIN_THREE_OUT(OUT_PIN_THREE_OUT), .IO_PINS_LO_OE_OUT(IO_PINS_LO_OE_OUT),
    .OUT_PINS_HI_OE_OUT(OUT_PINS_HI_OE_OUT), .MOD_RESET_OUT(MOD_RESET_OUT),
    .CONV_START_OUT(CONV_START_OUT), .CHANNEL_OUT(CHANNEL_OUT));

`default_nettype wire

// ---- sim/pgc_pin_partner.sv ----
/*
 * Far-side model: shared fault wire with its pull-up, and the sync source.
 * Assumes the bench commands an external pull-low and a sync hold.
 */
`timescale 1ns/1ns
`default_nettype none

module pgc_pin_partner (
    input  wire logic drive_oe_in,
    input  wire logic drive_level_in,
    input  wire logic pull_low_in,
    input  wire logic sync_hold_in,
    output logic      pin_level_out,
    output logic      sync_n_out
);
    // Wired-AND with one pull-up; released wire floats high
    assign pin_level_out = ((drive_oe_in && !drive_level_in) || pull_low_in) ? 1'b0 :
                           (drive_oe_in ? drive_level_in : 1'b1);
    assign sync_n_out = !sync_hold_in;
endmodule

`default_nettype wire

// ---- sim/pgc_pin_ctrl_bench.sv ----
/*
 * Self-checking bench for pgc_pin_ctrl: bus, pin modes, sync, mux, interrupt.
 * Assumes the partner model and the bound monitor are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none

module pgc_pin_ctrl_bench;
    import pgc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    logic        ext_low = 1'b0, sync_low = 1'b0, cfault = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd, w;
    logic [31:0] rdq[$], chq[$];
    int          errors = 0, num_checks = 0, starts = 0, cycles = 0, n, gap = 0;
    logic [3:0]  chan_q = 4'h0;
    wire logic [31:0] hrdata;
    wire logic [3:0]  chan;
    wire logic   hready, fpo, fpoe, bsw, p0, p1, p2, p3, lo_oe, hi_oe, modrst, cstart, irq;
    wire logic   fwire, sync_n;

    always #10 clk = ~clk;

    pgc_pin_ctrl uut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
        .SYNC_N_IN(sync_n), .FAULT_PIN_IN(fwire), .FAULT_PIN_OUT(fpo), .FAULT_PIN_OE_OUT(fpoe),
        .CONV_FAULT_IN(cfault), .BRIDGE_SWITCH_OUT(bsw), .IO_PIN_ZERO_OUT(p0),
        .IO_PIN_ONE_OUT(p1), .OUT_PIN_TWO_OUT(p2), .OUT_PIN_THREE_OUT(p3),
        .IO_PINS_LO_OE_OUT(lo_oe), .OUT_PINS_HI_OE_OUT(hi_oe), .MOD_RESET_OUT(modrst),
        .CONV_START_OUT(cstart), .CHANNEL_OUT(chan), .IRQ_OUT(irq));

    pgc_pin_partner far (.drive_oe_in(fpoe), .drive_level_in(fpo), .pull_low_in(ext_low),
        .sync_hold_in(sync_low), .pin_level_out(fwire), .sync_n_out(sync_n));

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (!hready) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Results are taken from the oldest note when they appear
    always @(posedge clk) begin
        if (rd_dp && hready) check(hrdata, rdq.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
        // Cycles since the channel last changed, against the settle count of 3
        chan_q <= chan;
        gap <= (chan != chan_q) ? 0 : gap + 1;
        if (cstart) begin
            starts <= starts + 1;
            if (chq.size() > 0) begin
                check({31'h0, gap >= 3}, 32'h1);
                check({28'h0, p3, p2, p1, p0}, chq[0]);
                check({28'h0, chan}, chq.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(37795));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ADDR_PIN_CFG, {16'h0, PIN_CFG_RESET});
        check({28'h0, bsw, hi_oe, lo_oe, fpoe}, 32'h0);
        rd(8'h40, 32'h0);
        repeat (4) begin
            rnd = $urandom;
            w = (rnd & 32'h7100) | 32'h0E00; // Top bit kept zero
            wr(ADDR_PIN_CFG, w);
            rd(ADDR_PIN_CFG, w);
            check({31'h0, bsw}, {31'h0, w[14]});
            check({31'h0, hi_oe}, {31'h0, w[13]});
            check({30'h0, fpoe, fwire}, {30'h0, 1'b1, w[8]});
        end
        wr(ADDR_PIN_CFG, 32'h0C00);
        cfault <= 1'b1;
        repeat (4) @(posedge clk);
        check({31'h0, fwire}, 32'h0);
        cfault <= 1'b0;
        repeat (4) @(posedge clk);
        check({31'h0, fwire}, 32'h1);
        wr(ADDR_PIN_CFG, 32'h0A00);
        ext_low <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_PIN_CFG, 32'h0A00);
        rd(ADDR_STATUS, 32'h80);
        check({31'h0, fpoe}, 32'h0);
        ext_low <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_PIN_CFG, 32'h0B00);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_PIN_CFG, 32'h0800);
        ext_low <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, 32'h0);
        ext_low <= 1'b0;
        sync_low <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, modrst}, 32'h1);
        wr(ADDR_PIN_CFG, 32'h0);
        repeat (6) @(posedge clk);
        check({31'h0, modrst}, 32'h0);
        sync_low <= 1'b0;
        wr(ADDR_SETTLE, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h4);
        wr(ADDR_PIN_CFG, 32'h1800);
        chq = '{32'h0, 32'h2, 32'h0};
        wr(ADDR_SEQ_CTRL, 32'h5);
        while (chq.size() > 0) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(ADDR_SEQ_CTRL, 32'h0);
        repeat (1100) @(posedge clk);
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h4);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h7);
        wr(ADDR_IRQ_STATUS, 32'h7);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h0);
        wr(ADDR_SEQ_CTRL, 32'h3);
        repeat (20) @(posedge clk);
        sync_low <= 1'b1;
        n = starts;
        repeat (10) @(posedge clk);
        check({31'h0, modrst}, 32'h0);
        repeat (2200) @(posedge clk);
        check(starts - n, 32'h0);
        sync_low <= 1'b0;
        repeat (20) @(posedge clk);
        check(starts - n, 32'h1);
        wr(ADDR_SEQ_CTRL, 32'h2); // Single channel: plain sync applies
        sync_low <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, modrst}, 32'h1);
        sync_low <= 1'b0;
        complete_run();
    end
endmodule

`default_nettype wire
